// ==== rtl/dfc_cfg.svh ====
`ifndef DFC_CFG_SVH
`define DFC_CFG_SVH
// register word addresses on the avalon word bus (word index)
`define DFC_A_FLOW_CTRL   4'h0
`define DFC_A_CHAN_STAT   4'h1
`define DFC_A_CHAN_CTRL   4'h2
`define DFC_A_DESC0       4'h3
`define DFC_A_DESC1       4'h4
`define DFC_A_CRC         4'h5
// flow_control_reg fields
`define DFC_B_EN          0
`define DFC_B_ABTM        1
`define DFC_B_PRIO_LO     2
`define DFC_B_CRC_ON_BIT       4
`define DFC_FLOW_CTRL_MSK 8'h1f
// channel_control_reg fields
`define DFC_B_ACK0        1
`define DFC_B_IEN0        2
`define DFC_B_ABT0        3
`define DFC_B_ACK1        5
`define DFC_B_IEN1        6
`define DFC_B_ABT1        7
// descriptor and peripheral constants
`define DFC_DESC_LAST     3'h4
`define DFC_EXP_MAX       8'h0d
`define DFC_NULL_ID       4'hf
`define DFC_CRC_POLY      16'h8005
`define DFC_CRC_RST       16'h0000
`endif

// ==== rtl/dfc_pkg.sv ====
package dfc_pkg;
  typedef enum logic [1:0] {
    DFC_PRIO_EQUAL = 2'h0,
    DFC_PRIO_CH0   = 2'h1,
    DFC_PRIO_CH1   = 2'h2,
    DFC_PRIO_RSVD  = 2'h3
  } dfc_prio_t;

  typedef enum logic [1:0] {
    DFC_IDLE,
    DFC_LOAD,
    DFC_RUN
  } dfc_chst_t;

  // per channel state
  typedef struct packed {
    dfc_chst_t   st;
    logic [2:0]  desc_idx;
    logic [3:0]  src_id;
    logic [3:0]  dst_id;
    logic [3:0]  exp;
    logic [15:0] flow_size;
    logic [15:0] pkts_left;
    logic [13:0] bytes_left;
    logic        abt_pend;
    logic        rd_lsb;
    logic        end_flag;
    logic        null_lsb;
  } dfc_chan_t;

  typedef struct packed {
    logic [7:0]  flow_ctrl;
    logic [1:0]  ien;
    logic [1:0]  abt;
    dfc_chan_t   ch0;
    dfc_chan_t   ch1;
    logic [15:0] crc;
    logic        crc_wr_lsb;
    logic        crc_rd_lsb;
    logic [7:0]  crc_seed_hi;
    logic        last_grant;
    logic        waitreq;
    logic [31:0] rdata;
    logic        irq;
    logic [1:0]  ack;
    logic [1:0]  take;
    logic [7:0]  bus_data;
    logic [3:0]  bus_src;
    logic [3:0]  bus_dst;
  } dfc_state_t;
endpackage

// ==== rtl/dfc_flow_controller.sv ====
// Functional notes
// - two independent channels, each moving bytes from its source to its destination.
// - no transfer activity while the controller enable bit is clear.
// - fifth descriptor byte starts channel; bytes move when source and destination ready.
// - packet size is two to the exponent, clamped to 8192 above exponent 13.
// - flow size counts packets; zero means continuous transfer.
// - peripheral id 15 is the null device; 0 to 8 real units, 9 to 14 reserved.
// - crc enable computes crc16 msb first, polynomial x16+x15+x2+1.
// - only channel 0 bytes update the crc.
// - reset crc to zero; two msb-first writes seed it, two reads return it.
// - clearing crc enable resets the crc write and read byte order.
// - a new transfer does not clear the crc accumulator.
// - null destination is always ready and drops every byte.
// - null source is always ready and sends the loaded crc, msb first.
// - equal priority with both channels ready alternates channels per byte.
// - priority field 00 equal, 01 channel 0, 10 channel 1; changes act at once.
// - busy sets when descriptor completes, clears at end of transfer or abort.
// - status shows live source and destination ready of each channel.
// - abort stops after current byte, or after current packet in delayed mode; sets end flag.
// - abort during descriptor write discards it and leaves end flag unchanged.
// - after abort, two descriptor reads return remaining packet count msb first.
// - hardware clears each abort bit once the abort is taken.
// - end flag clears only via acknowledge bit; writes to the flag are ignored.
// - interrupt requests when an end flag and its enable are both set.
`timescale 1ns/1ps
`include "dfc_cfg.svh"
module dfc_flow_controller
  import dfc_pkg::*;
(
  input  wire logic        ref_clk,      // 200 mhz clock
  input  wire logic        rst,          // sync reset, active high
  input  wire logic [3:0]  avs_address,  // word address
  input  wire logic        avs_read,     // read request
  input  wire logic        avs_write,    // write request
  input  wire logic [31:0] avs_writedata,// write data, low byte used
  input  wire logic [3:0]  avs_byteenable, // byte lanes
  output logic [31:0]      avs_readdata, // read data
  output logic             avs_waitrequest, // stall
  input  wire logic [15:0] periph_src_rdy, // source ready per peripheral id
  input  wire logic [15:0] periph_dst_rdy, // destination ready per peripheral id
  input  wire logic [7:0]  periph_rdata [16], // source byte per peripheral id
  output logic [7:0]       bus_data,     // byte on the multimedia bus
  output logic [3:0]       bus_src,      // id of source taking the move
  output logic [3:0]       bus_dst,      // id of destination taking the move
  output logic [1:0]       bus_take,     // one-cycle pulse per channel move
  output logic             irq           // end-of-flow interrupt request
);

  dfc_state_t s_ff, nxt_s;

  logic [7:0] stat_byte;
  logic [1:0] src_rdy, dst_rdy, can_go, grant;
  logic [7:0] src_byte [2];
  logic       en;
  dfc_prio_t  prio;

  assign en   = s_ff.flow_ctrl[`DFC_B_EN];
  assign prio = dfc_prio_t'(s_ff.flow_ctrl[`DFC_B_PRIO_LO +: 2]);

  ////////////////////////////////////////////////////////////////////////
  // crc16 byte step, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ `DFC_CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] pkt_len_m1(input logic [3:0] e);
    logic [3:0] k;
    k = (8'(e) > `DFC_EXP_MAX) ? 4'(`DFC_EXP_MAX) : e;
    return 14'((15'h1 << k) - 15'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // ready and source byte per channel
  always_comb begin
    dfc_chan_t c;
    c = s_ff.ch0;
    for (int i = 0; i < 2; i++) begin
      c = (i == 0) ? s_ff.ch0 : s_ff.ch1;
      src_rdy[i] = (c.src_id == `DFC_NULL_ID) ? 1'b1 : periph_src_rdy[c.src_id];
      dst_rdy[i] = (c.dst_id == `DFC_NULL_ID) ? 1'b1 : periph_dst_rdy[c.dst_id];
      src_byte[i] = (c.src_id != `DFC_NULL_ID) ? periph_rdata[c.src_id] :
                    (c.null_lsb ? s_ff.crc[7:0] : s_ff.crc[15:8]);
      can_go[i] = en && (c.st == DFC_RUN) && src_rdy[i] && dst_rdy[i];
    end
  end

  // arbitration: one byte per cycle on the shared bus
  always_comb begin
    grant = 2'b00;
    unique case (prio)
      DFC_PRIO_CH0: grant = can_go[0] ? 2'b01 : {can_go[1], 1'b0};
      DFC_PRIO_CH1: grant = can_go[1] ? 2'b10 : {1'b0, can_go[0]};
      default: begin
        if (&can_go) begin
          grant = s_ff.last_grant ? 2'b01 : 2'b10;
        end else begin
          grant = can_go;
        end
      end
    endcase
  end

  assign stat_byte = {dst_rdy[1], src_rdy[1], s_ff.ch1.end_flag, s_ff.ch1.st == DFC_RUN,
                      dst_rdy[0], src_rdy[0], s_ff.ch0.end_flag, s_ff.ch0.st == DFC_RUN};

  ////////////////////////////////////////////////////////////////////////
  // channel step: descriptor load, byte move, abort, end of flow
  function automatic dfc_chan_t chan_step(input dfc_chan_t c, input logic wr_desc,
      input logic rd_desc, input logic [7:0] d, input logic abt, input logic ack,
      input logic go, input logic abtm, output logic abt_taken);
    dfc_chan_t n;
    logic      pkt_end;
    n = c;
    abt_taken = 1'b0;
    pkt_end = (c.bytes_left == 14'h0);
    if (rd_desc) begin
      n.rd_lsb = ~c.rd_lsb;
    end
    if (abt && c.st == DFC_LOAD) begin
      n.st = DFC_IDLE;
      n.desc_idx = 3'h0;
      abt_taken = 1'b1;
    end else if (wr_desc && c.st != DFC_RUN) begin
      n.st = DFC_LOAD;
      n.desc_idx = c.desc_idx + 3'h1;
      unique case (c.desc_idx)
        3'h0: n.src_id = d[3:0];
        3'h1: n.dst_id = d[3:0];
        3'h2: n.exp = (d > 8'h0f) ? 4'hf : d[3:0];
        3'h3: n.flow_size[15:8] = d;
        default: n.flow_size[7:0] = d;
      endcase
      if (c.desc_idx == `DFC_DESC_LAST) begin
        n.st = DFC_RUN;
        n.desc_idx = 3'h0;
        n.pkts_left = {c.flow_size[15:8], d};
        n.bytes_left = pkt_len_m1(c.exp);
        n.null_lsb = 1'b0;
        n.rd_lsb = 1'b0;
      end
    end
    if (c.st == DFC_RUN) begin
      if (abt) begin
        abt_taken = 1'b1;
        if (!abtm) begin
          n.st = DFC_IDLE; // byte in flight has completed
          n.end_flag = 1'b1;
        end else begin
          n.abt_pend = 1'b1;
        end
      end
      if (go) begin
        n.null_lsb = ~c.null_lsb;
        n.bytes_left = c.bytes_left - 14'h1;
        if (pkt_end) begin
          n.bytes_left = pkt_len_m1(c.exp);
          if (c.flow_size != 16'h0) begin
            n.pkts_left = c.pkts_left - 16'h1;
          end
          if ((c.flow_size != 16'h0 && c.pkts_left == 16'h1) || c.abt_pend
              || (abt && abtm)) begin
            n.st = DFC_IDLE;
            n.end_flag = 1'b1;
            n.abt_pend = 1'b0;
          end
        end
      end
      if (n.st == DFC_IDLE) begin
        n.abt_pend = 1'b0;
      end
    end
    if (ack) begin
      n.end_flag = n.end_flag & ~(c.st == DFC_RUN && n.st == DFC_IDLE) ? 1'b0 : n.end_flag;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       wr, rd, rq, wr0, wr1, rd0, rd1, tk0, tk1;
    logic [7:0] wd;
    logic [1:0] abt_now;
    nxt_s = s_ff;
    wr = avs_write && s_ff.waitreq == 1'b0 && avs_byteenable[0];
    rd = avs_read && s_ff.waitreq == 1'b0;
    // read data is prepared in the wait cycle so it stands while waitrequest is low
    rq = avs_read && s_ff.waitreq == 1'b1;
    wd = avs_writedata[7:0];
    wr0 = wr && avs_address == `DFC_A_DESC0;
    wr1 = wr && avs_address == `DFC_A_DESC1;
    rd0 = rd && avs_address == `DFC_A_DESC0;
    rd1 = rd && avs_address == `DFC_A_DESC1;
    tk0 = 1'b0;
    tk1 = 1'b0;
    // one wait state: every access answers on the second edge
    nxt_s.waitreq = ~((avs_read || avs_write) && s_ff.waitreq);
    if (!(avs_read || avs_write)) begin
      nxt_s.waitreq = 1'b1;
    end
    nxt_s.ack = 2'b00;
    if (wr && avs_address == `DFC_A_FLOW_CTRL) begin
      nxt_s.flow_ctrl = wd & `DFC_FLOW_CTRL_MSK;
      if (!wd[`DFC_B_CRC_ON_BIT]) begin
        nxt_s.crc_wr_lsb = 1'b0;
        nxt_s.crc_rd_lsb = 1'b0;
      end
    end
    if (wr && avs_address == `DFC_A_CHAN_CTRL) begin
      nxt_s.ien = {wd[`DFC_B_IEN1], wd[`DFC_B_IEN0]};
      nxt_s.abt = s_ff.abt | {wd[`DFC_B_ABT1], wd[`DFC_B_ABT0]};
      nxt_s.ack = {wd[`DFC_B_ACK1], wd[`DFC_B_ACK0]};
    end
    abt_now = s_ff.abt & {en, en};
    nxt_s.ch0 = chan_step(s_ff.ch0, wr0, rd0, wd, abt_now[0], s_ff.ack[0], grant[0],
                          s_ff.flow_ctrl[`DFC_B_ABTM], tk0);
    nxt_s.ch1 = chan_step(s_ff.ch1, wr1, rd1, wd, abt_now[1], s_ff.ack[1], grant[1],
                          s_ff.flow_ctrl[`DFC_B_ABTM], tk1);
    if (tk0 || (s_ff.ch0.st == DFC_IDLE)) begin
      nxt_s.abt[0] = 1'b0; // no flow to abort when idle
    end
    if (tk1 || (s_ff.ch1.st == DFC_IDLE)) begin
      nxt_s.abt[1] = 1'b0;
    end
    if (wr && avs_address == `DFC_A_CHAN_CTRL) begin
      nxt_s.abt = nxt_s.abt | ({wd[`DFC_B_ABT1], wd[`DFC_B_ABT0]} & {en, en});
    end
    // crc register access and channel 0 accumulation
    if (wr && avs_address == `DFC_A_CRC) begin
      nxt_s.crc_wr_lsb = ~s_ff.crc_wr_lsb;
      if (!s_ff.crc_wr_lsb) begin
        nxt_s.crc_seed_hi = wd;
      end else begin
        nxt_s.crc = {s_ff.crc_seed_hi, wd};
      end
    end else if (grant[0] && s_ff.flow_ctrl[`DFC_B_CRC_ON_BIT]) begin
      nxt_s.crc = crc_step(s_ff.crc, src_byte[0]);
    end
    if (rd && avs_address == `DFC_A_CRC) begin
      nxt_s.crc_rd_lsb = ~s_ff.crc_rd_lsb;
    end
    // read mux
    nxt_s.rdata = 32'h0;
    if (rq) begin
      unique case (avs_address)
        `DFC_A_FLOW_CTRL: nxt_s.rdata[7:0] = s_ff.flow_ctrl;
        `DFC_A_CHAN_STAT: nxt_s.rdata[7:0] = stat_byte;
        `DFC_A_CHAN_CTRL: nxt_s.rdata[7:0] = {s_ff.abt[1], s_ff.ien[1], 2'b00,
                                              s_ff.abt[0], s_ff.ien[0], 2'b00};
        `DFC_A_DESC0: nxt_s.rdata[7:0] = s_ff.ch0.rd_lsb ? s_ff.ch0.pkts_left[7:0]
                                                         : s_ff.ch0.pkts_left[15:8];
        `DFC_A_DESC1: nxt_s.rdata[7:0] = s_ff.ch1.rd_lsb ? s_ff.ch1.pkts_left[7:0]
                                                         : s_ff.ch1.pkts_left[15:8];
        `DFC_A_CRC: nxt_s.rdata[7:0] = s_ff.crc_rd_lsb ? s_ff.crc[7:0] : s_ff.crc[15:8];
        default: nxt_s.rdata = 32'h0;
      endcase
    end
    // bus move outputs
    nxt_s.take = grant;
    nxt_s.bus_data = grant[1] ? src_byte[1] : src_byte[0];
    nxt_s.bus_src = grant[1] ? s_ff.ch1.src_id : s_ff.ch0.src_id;
    nxt_s.bus_dst = grant[1] ? s_ff.ch1.dst_id : s_ff.ch0.dst_id;
    if (|grant) begin
      nxt_s.last_grant = grant[1];
    end
    nxt_s.irq = (nxt_s.ch0.end_flag && nxt_s.ien[0]) ||
                (nxt_s.ch1.end_flag && nxt_s.ien[1]);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.waitreq <= 1'b1;
      s_ff.crc <= `DFC_CRC_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata    = s_ff.rdata;
  assign avs_waitrequest = s_ff.waitreq;
  assign bus_data        = s_ff.bus_data;
  assign bus_src         = s_ff.bus_src;
  assign bus_dst         = s_ff.bus_dst;
  assign bus_take        = s_ff.take;
  assign irq             = s_ff.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_disabled_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !en |-> grant == 2'b00) else $error("move while disabled");
  a_grant_onehot: assert property (@(posedge ref_clk) disable iff (rst)
    grant != 2'b11) else $error("both channels granted");
  a_alt_equal: assert property (@(posedge ref_clk) disable iff (rst)
    (prio == DFC_PRIO_EQUAL && &can_go && grant == 2'b01) ##1 (prio == DFC_PRIO_EQUAL && &can_go)
    |-> grant == 2'b10) else $error("no alternation");
  a_prio_ch0: assert property (@(posedge ref_clk) disable iff (rst)
    prio == DFC_PRIO_CH0 && can_go[0] |-> grant == 2'b01) else $error("ch0 not preferred");
  a_prio_ch1: assert property (@(posedge ref_clk) disable iff (rst)
    prio == DFC_PRIO_CH1 && can_go[1] |-> grant == 2'b10) else $error("ch1 not preferred");
  a_take_follows: assert property (@(posedge ref_clk) disable iff (rst)
    grant[0] |=> bus_take[0]) else $error("take pulse missing");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    s_ff.ch0.end_flag && s_ff.ien[0] |-> irq) else $error("irq not raised");
  a_crc_ch1_only: assert property (@(posedge ref_clk) disable iff (rst)
    grant == 2'b10 && !(avs_write && avs_address == `DFC_A_CRC) |=> $stable(s_ff.crc))
    else $error("ch1 changed crc");
  a_abort_cleared: assert property (@(posedge ref_clk) disable iff (rst)
    s_ff.abt[0] && s_ff.ch0.st == DFC_RUN |=> !s_ff.abt[0] || $rose(s_ff.abt[0]))
    else $error("abort bit stuck");
  c_both_run: cover property (@(posedge ref_clk) &can_go);
  c_end0: cover property (@(posedge ref_clk) $rose(s_ff.ch0.end_flag));
  c_null_src: cover property (@(posedge ref_clk) grant[0] && s_ff.ch0.src_id == `DFC_NULL_ID);
endmodule

// ==== sim/dfc_periph_model.sv ====
`timescale 1ns/1ps
module dfc_periph_model (
  input  wire logic        ref_clk,   // bus clock
  input  wire logic        rst,       // sync reset
  input  wire logic [15:0] src_en,    // sources allowed to offer data
  input  wire logic [15:0] dst_en,    // destinations allowed to accept
  input  wire logic [1:0]  bus_take,  // move pulse per channel
  input  wire logic [3:0]  bus_src,   // source id of the move
  output logic [15:0]      src_rdy,   // ready per source id
  output logic [15:0]      dst_rdy,   // ready per destination id
  output logic [7:0]       rdata [16] // byte offered per source id
);
  logic [7:0] cnt [16];
  assign src_rdy = src_en;
  assign dst_rdy = dst_en;
  // an idle source shows inverted data, so a stale byte never looks good
  // a byte taken in this cycle is already consumed, so the next one is offered at once
  always_comb for (int i = 0; i < 16; i++) rdata[i] = src_en[i] ?
    {4'(i), 4'h0} + cnt[i] + {7'h0, (|bus_take) && (bus_src == 4'(i))} : ~cnt[i];
  always_ff @(posedge ref_clk) begin
    if (rst) for (int i = 0; i < 16; i++) cnt[i] <= 8'h00;
    else if (|bus_take) cnt[bus_src] <= cnt[bus_src] + 8'h01;
  end
endmodule

// ==== sim/dfc_flow_controller_tb.sv ====
`timescale 1ns/1ps
`include "dfc_cfg.svh"
module dfc_flow_controller_tb
  import dfc_pkg::*;
;
  localparam logic [3:0] A_FC = `DFC_A_FLOW_CTRL;
  localparam logic [3:0] A_ST = `DFC_A_CHAN_STAT;
  localparam logic [3:0] A_CC = `DFC_A_CHAN_CTRL;
  localparam logic [3:0] A_D0 = `DFC_A_DESC0;
  localparam logic [3:0] A_D1 = `DFC_A_DESC1;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic [15:0] s_en = 16'h0;
  logic [15:0] d_en = 16'h0;
  logic [15:0] s_rdy;
  logic [15:0] d_rdy;
  logic [7:0]  p_rd [16];
  logic [7:0]  b_dat;
  logic [3:0]  b_src;
  logic [1:0]  take;
  logic        irq;
  logic [7:0]  got;
  logic [15:0] v;
  logic [15:0] nd1 = 16'h0;
  logic [15:0] crc_e;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n0 = 0;
  int          n1 = 0;
  dfc_flow_controller u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .periph_src_rdy(s_rdy), .periph_dst_rdy(d_rdy), .periph_rdata(p_rd),
    .bus_data(b_dat), .bus_src(b_src), .bus_dst(), .bus_take(take), .irq(irq));
  dfc_periph_model u_far (.ref_clk(ref_clk), .rst(rst), .src_en(s_en), .dst_en(d_en),
    .bus_take(take), .bus_src(b_src), .src_rdy(s_rdy), .dst_rdy(d_rdy), .rdata(p_rd));
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n0 <= n0 + int'(take[0]);
    n1 <= n1 + int'(take[1]);
    if (take[1] === 1'b1) nd1 <= {nd1[7:0], b_dat};
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0);
    return c;
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, s, e);
    end
  endtask
  // request held until the rising edge at which waitrequest is sampled low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (wreq === 1'b0) begin
        got = rdat[7:0];
        break;
      end
    end
    if (i == 50) hang();
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdr(input logic [3:0] a);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic rd2(input logic [3:0] a);
    rdr(a);
    v[15:8] = got;
    rdr(a);
    v[7:0] = got;
  endtask
  task automatic desc(input logic [3:0] a, input logic [7:0] s, input logic [7:0] t,
                      input logic [7:0] e, input logic [15:0] f);
    wrt(a, s);
    wrt(a, t);
    wrt(a, e);
    wrt(a, f[15:8]);
    wrt(a, f[7:0]);
  endtask
  task automatic idle;
    int i;
    for (i = 0; i < 4000; i++) begin
      rdr(A_ST);
      if ((got & 8'h11) === 8'h00) break;
    end
    if (i == 4000) hang();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset;
    rdr(A_ST);
    chk(got, 8'h00, "stat");
    rdr(A_CC);
    chk(got, 8'h00, "cctl");
    rdr(4'h9);
    chk(got, 8'h00, "unmapped");
    rd2(`DFC_A_CRC);
    chk(v, 16'h0000, "crc rst");
    chk(16'(irq), 16'h0, "irq rst");
  endtask
  task automatic s_gate;
    wrt(A_FC, 8'h01);
    desc(A_D0, 8'h01, 8'h0f, 8'h01, 16'h0002);
    rdr(A_ST);
    chk(got, 8'h09, "busy rdy");
    wrt(A_FC, 8'h00);
    s_en <= 16'h0002;
    repeat (20) @(posedge ref_clk);
    chk(16'(n0), 16'h0, "gated");
    s_en <= 16'h0000;
    wrt(A_FC, 8'h11);
    wrt(`DFC_A_CRC, 8'h12);
    wrt(`DFC_A_CRC, 8'h34);
    s_en <= 16'h0002;
    idle();
    chk(16'(n0), 16'h4, "bytes");
    rdr(A_ST);
    chk(got, 8'h0e, "end0");
    chk(16'(irq), 16'h0, "irq masked");
    wrt(A_CC, 8'h04);
    repeat (2) @(negedge ref_clk);
    chk(16'(irq), 16'h1, "irq on");
    wrt(A_ST, 8'h00);
    rdr(A_ST);
    chk(got, 8'h0e, "flag kept");
    wrt(A_CC, 8'h06);
    repeat (2) @(negedge ref_clk);
    chk(16'(irq), 16'h0, "irq ack");
    crc_e = 16'h1234;
    for (int k = 0; k < 4; k++) crc_e = crc_b(crc_e, 8'h10 + 8'(k));
    rd2(`DFC_A_CRC);
    chk(v, crc_e, "crc");
  endtask
  task automatic s_crc;
    int b;
    s_en <= 16'h0006;
    d_en <= 16'h0008;
    b = n1;
    desc(A_D1, 8'h02, 8'h0f, 8'h0e, 16'h0001);
    idle();
    chk(16'(n1 - b), 16'd8192, "clamp");
    rd2(`DFC_A_CRC);
    chk(v, crc_e, "ch1 crc");
    desc(A_D1, 8'h0f, 8'h03, 8'h01, 16'h0001);
    idle();
    chk(nd1, crc_e, "null src");
    desc(A_D0, 8'h01, 8'h0f, 8'h00, 16'h0001);
    idle();
    crc_e = crc_b(crc_e, 8'h14);
    rd2(`DFC_A_CRC);
    chk(v, crc_e, "carry");
  endtask
  task automatic s_prio;
    dfc_prio_t p [3] = '{DFC_PRIO_CH0, DFC_PRIO_CH1, DFC_PRIO_EQUAL};
    int a0, a1;
    s_en <= 16'h0030;
    d_en <= 16'h00c0;
    desc(A_D0, 8'h04, 8'h06, 8'h00, 16'h0000);
    desc(A_D1, 8'h05, 8'h07, 8'h00, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wrt(A_FC, {4'h0, p[i], 2'b01});
      repeat (4) @(posedge ref_clk);
      a0 = n0;
      a1 = n1;
      repeat (20) @(posedge ref_clk);
      a0 = n0 - a0;
      a1 = n1 - a1;
      chk({a0 > 0, a1 > 0, (a0 - a1) * (a0 - a1) < 2 || p[i] != DFC_PRIO_EQUAL},
          {p[i] != DFC_PRIO_CH1, p[i] != DFC_PRIO_CH0, 1'b1}, "share");
    end
    wrt(A_FC, 8'h05);
    s_en <= 16'h0020;
    a1 = n1;
    repeat (20) @(posedge ref_clk);
    chk(16'(n1 - a1 > 5), 16'h1, "fallback");
    wrt(A_CC, 8'h88);
    idle();
    rdr(A_ST);
    chk(got & 8'h33, 8'h22, "abort");
    rdr(A_CC);
    chk(got & 8'h88, 8'h00, "abt clr");
    wrt(A_CC, 8'h22);
  endtask
  task automatic s_delay;
    int b, i;
    s_en <= 16'h0020;
    wrt(A_FC, 8'h03);
    b = n1;
    desc(A_D1, 8'h05, 8'h07, 8'h02, 16'h000a);
    for (i = 0; i < 200 && n1 - b < 6; i++) @(posedge ref_clk);
    wrt(A_CC, 8'h80);
    idle();
    b = n1 - b;
    chk(16'(b % 4), 16'h0, "pkt end");
    rd2(A_D1);
    chk(v, 16'(10 - b / 4), "remain");
    rdr(A_ST);
    chk(got & 8'h30, 8'h20, "end1");
    wrt(A_CC, 8'h20);
  endtask
  task automatic s_partial;
    int b;
    wrt(A_D1, 8'h05);
    wrt(A_D1, 8'h07);
    wrt(A_CC, 8'h80);
    rdr(A_ST);
    chk(got & 8'h30, 8'h00, "no end");
    b = n1;
    desc(A_D1, 8'h05, 8'h07, 8'h01, 16'h0003);
    idle();
    chk(16'(n1 - b), 16'h6, "fresh desc");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    s_reset();
    s_gate();
    s_crc();
    s_prio();
    s_delay();
    s_partial();
    conclude();
  end
endmodule
